// >>> ppcb_pkg.sv
`default_nettype none
package ppcb_pkg;
    // Register locations
    localparam logic [7:0] ADDR_PROGRAM_STATUS = 8'h00;
    localparam logic [7:0] ADDR_FIRST_SETTING = 8'h01;
    localparam logic [7:0] ADDR_LAST_SETTING = 8'h0A;
    localparam logic [7:0] ADDR_PROGRAM_KEY = 8'h0B;
    localparam int NUM_SETTINGS = 10;
    // Indices into the settings array
    localparam int IDX_SYSTEM_CONFIG = 1;
    localparam int IDX_OVERVOLTAGE_THRESHOLD = 2;
    localparam int IDX_OVERVOLTAGE_HYST_DELAY = 3;
    localparam int IDX_BALANCING_CONFIG = 10;
    // System configuration fields
    localparam int CELL_COUNT_SELECT_LSB = 5;
    localparam int CHARGER_THERMAL_OVERRIDE_BIT = 4;
    localparam int THERMAL_SENSE_ON_BIT = 3;
    localparam int OVERTEMP_RECOVERY_SELECT_BIT = 2;
    localparam int RESERVED_SAFETY_BIT = 1;
    localparam int CURRENT_FAULT_RECOVERY_SELECT_BIT = 0;
    // Other fields
    localparam int OVERVOLTAGE_VIA_THERMISTOR_BIT = 7;
    localparam int BALANCE_MODE_LSB = 6;
    localparam int VOLTAGE_GOOD_FLAG_BIT = 0;
    // Cell count: code 0 selects the full stack, each step one less
    localparam logic [3:0] CELL_COUNT_MAX = 4'hA;
    localparam logic [3:0] CELL_COUNT_MIN = 4'h4;
    // Overvoltage trip mapping in millivolts
    localparam logic [12:0] OV_TRIP_BASE_MV = 13'h0AF0;
    localparam logic [12:0] OV_TRIP_STEP_MV = 13'h0019;
    // Key location values and reset value
    localparam logic [7:0] KEY_RESET_VALUE = 8'h00;
    localparam logic [7:0] KEY_UNLOCK_PROGRAM = 8'h41;
    localparam logic [7:0] KEY_PRE_READ = 8'h62;
    // Serial port: 7-bit device address
    localparam logic [6:0] SERIAL_DEVICE_ADDR = 7'h10;
    // Balancing modes
    localparam logic [1:0] BALANCE_OFF = 2'h0;
    localparam logic [1:0] BALANCE_ALWAYS = 2'h1;
    localparam logic [1:0] BALANCE_WHILE_CHARGING = 2'h2;
    // Serial engine states, one-hot
    typedef enum logic [3:0] {
        SER_IDLE = 4'b0001,
        SER_ADDR = 4'b0010,
        SER_WRITE = 4'b0100,
        SER_READ = 4'b1000
    } ppcb_ser_state_type;
endpackage
`default_nettype wire

// >>> ppcb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ppcb_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    // Two flops; only the second reads the first
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            stage1_reg <= '0;
            sync_out <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule // ppcb_sync
`default_nettype wire

// >>> ppcb_bank.sv
// Function
// - Load counts as removed when load-return sense falls below about 2 V.
// - With overvoltage_via_thermistor set, overvoltage pulls thermistor line low.
// - Overvoltage drops discharge gate only; undervoltage drops both gates.
// - Current faults auto-recover on load removal; with recovery select set a charger is also needed.
// - Three-bit cell-count field selects 4 to 10 cells; 000 means 10.
// - Zero-delay input low uses programmed delays; high forces minimum delays.
// - Serial port works only while zero-delay input is high.
// - Ten settings registers at 0x01 to 0x0A plus one volatile key location.
// - Thermal sensing only when enabled; recovery select adds load removal.
// - Charger thermal override: thermal protection only without charger present.
// - Charger thermal override beats overtemp recovery select.
// - Current fault recovery: load removal alone, or plus charger attached.
// - Overvoltage code maps to 2.800 V plus 25 mV per step.
// - Balancing limited to charging only when charger status is detectable.
// - Programming unlocked only by key 0x41; 0x62 pre-reads; key resets 0x00.
`timescale 1ns/1ps
`default_nettype none
module ppcb_bank (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Serial programming pins (open drain data)
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    // Mode and presence pins
    input wire logic zero_delay_test_input_in,
    input wire logic load_return_below_2v_in,
    input wire logic charger_status_input_in,
    input wire logic voltage_good_flag_in,
    // Fault events from the analog front end
    input wire logic overvoltage_event_in,
    input wire logic undervoltage_event_in,
    input wire logic overtemp_event_in,
    input wire logic discharge_overcurrent_in,
    input wire logic discharge_short_circuit_in,
    // Nonvolatile storage
    input wire logic [ppcb_pkg::NUM_SETTINGS*8-1:0] nv_image_in,
    input wire logic nv_program_strobe_in,
    output logic nv_write_pulse_out,
    output logic [ppcb_pkg::NUM_SETTINGS*8-1:0] nv_write_data_out,
    // Protection outputs
    output logic discharge_gate_drive_out,
    output logic charge_gate_drive_out,
    output logic thermistor_line_oe_out,
    output logic delay_minimum_out,
    output logic thermal_sense_on_out,
    output logic [3:0] cell_count_out,
    output logic [12:0] overvoltage_trip_mv_out,
    output logic balance_enable_out
);
    import ppcb_pkg::*;

    localparam int SYNC_W = 12;

    logic [SYNC_W-1:0] sync_vec;
    logic scl_s, sda_s, zd_s, load_low_s, chg_s, voltage_good_flag_s;
    logic ov_s, uv_s, ot_s, oc_s, sc_s, prog_s;
    logic scl_prev_reg, sda_prev_reg, prog_prev_reg;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0] shadow_reg [1:NUM_SETTINGS];
    logic [7:0] active_reg [1:NUM_SETTINGS];
    logic [7:0] key_reg;
    logic boot_done_reg;
    ppcb_ser_state_type ser_state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] pointer_reg;
    logic pointer_set_reg;
    logic master_nack_reg;
    logic [7:0] read_data;
    logic write_strobe;
    logic [7:0] write_addr;
    logic load_removed;
    logic current_fault_reg, overtemp_fault_reg;
    logic thermal_active, ot_clear;
    logic [7:0] system_config;
    logic [2:0] cell_code;

    // Pins cross into the clock domain first
    ppcb_sync #(
        .WIDTH(SYNC_W)
    ) u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in({serial_clock_in, serial_data_in,
                   zero_delay_test_input_in, load_return_below_2v_in,
                   charger_status_input_in, voltage_good_flag_in,
                   overvoltage_event_in, undervoltage_event_in,
                   overtemp_event_in, discharge_overcurrent_in,
                   discharge_short_circuit_in, nv_program_strobe_in}),
        .sync_out(sync_vec)
    );

    assign {scl_s, sda_s, zd_s, load_low_s, chg_s, voltage_good_flag_s,
            ov_s, uv_s, ot_s, oc_s, sc_s, prog_s} = sync_vec;

    // Edge history of synchronised pins
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            prog_prev_reg <= 1'b0;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            prog_prev_reg <= prog_s;
        end
    end

    // Bus conditions; all gated by test mode
    assign scl_rise = zd_s && scl_s && !scl_prev_reg;
    assign scl_fall = zd_s && !scl_s && scl_prev_reg;
    assign start_cond = zd_s && scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
    assign stop_cond = zd_s && scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

    // Read mux; unmapped locations read as zero
    always_comb begin
        read_data = 8'h00;
        if (pointer_reg == ADDR_PROGRAM_STATUS) begin
            read_data[VOLTAGE_GOOD_FLAG_BIT] = voltage_good_flag_s;
        end else if (pointer_reg >= ADDR_FIRST_SETTING &&
                     pointer_reg <= ADDR_LAST_SETTING) begin
            read_data = shadow_reg[pointer_reg[3:0]];
        end else if (pointer_reg == ADDR_PROGRAM_KEY) begin
            read_data = key_reg;
        end
    end

    // A data byte lands at the eighth falling edge of a write byte
    assign write_strobe = scl_fall && (bit_cnt_reg == 4'h8) &&
        (ser_state_reg == SER_WRITE) && pointer_set_reg;
    assign write_addr = pointer_reg;

    // Serial engine: address, pointer, data, auto-increment
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !zd_s) begin
            ser_state_reg <= SER_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            pointer_reg <= 8'h00;
            pointer_set_reg <= 1'b0;
            master_nack_reg <= 1'b0;
            serial_data_oe_out <= 1'b0;
        end else if (start_cond) begin
            ser_state_reg <= SER_ADDR;
            bit_cnt_reg <= 4'h0;
            pointer_set_reg <= 1'b0;
            serial_data_oe_out <= 1'b0;
        end else if (stop_cond) begin
            ser_state_reg <= SER_IDLE;
            bit_cnt_reg <= 4'h0;
            serial_data_oe_out <= 1'b0;
        end else if (scl_rise && ser_state_reg != SER_IDLE) begin
            if (bit_cnt_reg < 4'h8) begin
                rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
            end else begin
                master_nack_reg <= sda_s;
            end
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (scl_fall && ser_state_reg != SER_IDLE) begin
            unique case (ser_state_reg)
                SER_ADDR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        if (rx_shift_reg[7:1] == SERIAL_DEVICE_ADDR) begin
                            serial_data_oe_out <= 1'b1;
                            ser_state_reg <= rx_shift_reg[0] ?
                                SER_READ : SER_WRITE;
                        end else begin
                            ser_state_reg <= SER_IDLE;
                        end
                    end
                end
                SER_WRITE: begin
                    if (bit_cnt_reg == 4'h8) begin
                        // Acknowledge every byte, mapped or not
                        serial_data_oe_out <= 1'b1;
                        if (!pointer_set_reg) begin
                            pointer_reg <= rx_shift_reg;
                            pointer_set_reg <= 1'b1;
                        end else begin
                            pointer_reg <= pointer_reg + 8'h01;
                        end
                    end else if (bit_cnt_reg == 4'h9) begin
                        serial_data_oe_out <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                SER_READ: begin
                    if (bit_cnt_reg == 4'h9) begin
                        // Nack seen at the ninth rise ends the read
                        if (master_nack_reg) begin
                            ser_state_reg <= SER_IDLE;
                        end else begin
                            tx_shift_reg <= read_data;
                            serial_data_oe_out <= !read_data[7];
                            pointer_reg <= pointer_reg + 8'h01;
                        end
                        bit_cnt_reg <= 4'h0;
                    end else if (bit_cnt_reg == 4'h8) begin
                        serial_data_oe_out <= 1'b0;
                    end else if (bit_cnt_reg != 4'h0) begin
                        serial_data_oe_out <=
                            !tx_shift_reg[3'h7 - bit_cnt_reg[2:0]];
                    end
                end
                default: begin
                    ser_state_reg <= SER_IDLE;
                end
            endcase
        end
    end

    // Data line only ever pulls low
    always_ff @(posedge sys_clk_in) begin
        serial_data_out <= 1'b0;
    end

    // Key location: volatile, cleared by reset
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            key_reg <= KEY_RESET_VALUE;
        end else if (write_strobe && write_addr == ADDR_PROGRAM_KEY) begin
            key_reg <= rx_shift_reg;
        end
    end

    // Shadow copy: boot load, pre-read, serial writes
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            boot_done_reg <= 1'b0;
            for (int i = 1; i <= NUM_SETTINGS; i++) begin
                shadow_reg[i] <= 8'h00;
            end
        end else if (!boot_done_reg ||
                     (write_strobe && write_addr == ADDR_PROGRAM_KEY &&
                      rx_shift_reg == KEY_PRE_READ)) begin
            boot_done_reg <= 1'b1;
            for (int i = 1; i <= NUM_SETTINGS; i++) begin
                shadow_reg[i] <= nv_image_in[(i-1)*8 +: 8];
            end
        end else if (write_strobe && write_addr >= ADDR_FIRST_SETTING &&
                     write_addr <= ADDR_LAST_SETTING) begin
            shadow_reg[write_addr[3:0]] <= rx_shift_reg;
        end
    end

    // Active copy steers protection; changes only on boot or commit
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            nv_write_pulse_out <= 1'b0;
            nv_write_data_out <= '0;
            for (int i = 1; i <= NUM_SETTINGS; i++) begin
                active_reg[i] <= 8'h00;
            end
        end else if (!boot_done_reg) begin
            nv_write_pulse_out <= 1'b0;
            for (int i = 1; i <= NUM_SETTINGS; i++) begin
                active_reg[i] <= nv_image_in[(i-1)*8 +: 8];
            end
        end else if (prog_s && !prog_prev_reg &&
                     key_reg == KEY_UNLOCK_PROGRAM && zd_s) begin
            nv_write_pulse_out <= 1'b1;
            for (int i = 1; i <= NUM_SETTINGS; i++) begin
                active_reg[i] <= shadow_reg[i];
                nv_write_data_out[(i-1)*8 +: 8] <= shadow_reg[i];
            end
        end else begin
            nv_write_pulse_out <= 1'b0;
        end
    end

    assign system_config = active_reg[IDX_SYSTEM_CONFIG];
    assign cell_code = system_config[CELL_COUNT_SELECT_LSB +: 3];
    // Comparator output already encodes the 2 V trip
    assign load_removed = load_low_s;
    // Override: thermal protection suppressed while a charger is present
    assign thermal_active = system_config[THERMAL_SENSE_ON_BIT] &&
        !(system_config[CHARGER_THERMAL_OVERRIDE_BIT] && chg_s);
    // Override wins over recovery select
    assign ot_clear = (system_config[CHARGER_THERMAL_OVERRIDE_BIT] && chg_s) ||
        !system_config[THERMAL_SENSE_ON_BIT] ||
        (!ot_s && (!system_config[OVERTEMP_RECOVERY_SELECT_BIT] ||
                   load_removed));

    // Current fault latch; set wins over clear
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            current_fault_reg <= 1'b0;
        end else if (oc_s || sc_s) begin
            current_fault_reg <= 1'b1;
        end else if (load_removed &&
                     (!system_config[CURRENT_FAULT_RECOVERY_SELECT_BIT] ||
                      chg_s)) begin
            current_fault_reg <= 1'b0;
        end
    end

    // Overtemperature latch; charger override clears immediately
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            overtemp_fault_reg <= 1'b0;
        end else if (ot_s && thermal_active) begin
            overtemp_fault_reg <= 1'b1;
        end else if (ot_clear) begin
            overtemp_fault_reg <= 1'b0;
        end
    end

    // Gate controls: high means FET on
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            discharge_gate_drive_out <= 1'b0;
            charge_gate_drive_out <= 1'b0;
            thermistor_line_oe_out <= 1'b0;
        end else begin
            discharge_gate_drive_out <= !(ov_s || uv_s ||
                current_fault_reg || overtemp_fault_reg);
            charge_gate_drive_out <= !(uv_s || overtemp_fault_reg);
            thermistor_line_oe_out <= ov_s &&
                active_reg[IDX_OVERVOLTAGE_HYST_DELAY]
                          [OVERVOLTAGE_VIA_THERMISTOR_BIT];
        end
    end

    // Decoded settings for the analog side
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            delay_minimum_out <= 1'b0;
            thermal_sense_on_out <= 1'b0;
            cell_count_out <= CELL_COUNT_MAX;
            overvoltage_trip_mv_out <= OV_TRIP_BASE_MV;
            balance_enable_out <= 1'b0;
        end else begin
            delay_minimum_out <= zd_s;
            thermal_sense_on_out <= thermal_active;
            // Codes past six saturate at the minimum count of four cells
            cell_count_out <= (cell_code > 3'h6) ? CELL_COUNT_MIN :
                CELL_COUNT_MAX - {1'b0, cell_code};
            overvoltage_trip_mv_out <= OV_TRIP_BASE_MV + OV_TRIP_STEP_MV *
                {7'h00, active_reg[IDX_OVERVOLTAGE_THRESHOLD][5:0]};
            unique case (active_reg[IDX_BALANCING_CONFIG]
                         [BALANCE_MODE_LSB +: 2])
                BALANCE_OFF: balance_enable_out <= 1'b0;
                BALANCE_ALWAYS: balance_enable_out <= 1'b1;
                BALANCE_WHILE_CHARGING: balance_enable_out <= chg_s;
                default: balance_enable_out <= 1'b1;
            endcase
        end
    end
endmodule // ppcb_bank
`default_nettype wire

// >>> ppcb_equipment_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppcb_equipment_model (
    // Serial data wire
    input wire logic host_pull_low_in,
    input wire logic dut_pull_low_in,
    output logic serial_data_out,
    // Charger and load
    input wire logic charger_on_in,
    input wire logic [15:0] load_return_mv_in,
    output logic charger_status_out,
    output logic load_below_2v_out
);
    // Open drain with pull-up, so a released line reads high
    assign serial_data_out = !(host_pull_low_in || dut_pull_low_in);
    // No charge FET: equipment itself flags an attached charger
    assign charger_status_out = charger_on_in;
    // Load-return comparator trips under 2 V after the bleed
    assign load_below_2v_out = load_return_mv_in < 16'h07D0;
endmodule // ppcb_equipment_model
`default_nettype wire

// >>> ppcb_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ppcb_bank_assertions
    import ppcb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Watched inputs
    input wire logic zero_delay_test_input_in,
    input wire logic load_return_below_2v_in,
    input wire logic overvoltage_event_in,
    input wire logic undervoltage_event_in,
    input wire logic discharge_overcurrent_in,
    // Watched outputs
    input wire logic serial_data_oe_out,
    input wire logic nv_write_pulse_out,
    input wire logic discharge_gate_drive_out,
    input wire logic charge_gate_drive_out,
    input wire logic thermistor_line_oe_out,
    input wire logic delay_minimum_out,
    input wire logic [3:0] cell_count_out,
    input wire logic [12:0] overvoltage_trip_mv_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Fault held four samples, then load left in place
    sequence s_fault_seen;
        (discharge_overcurrent_in && !load_return_below_2v_in)[*4];
    endsequence
    sequence s_load_stays;
        (!load_return_below_2v_in)[*4];
    endsequence
    a_reset_values: assert property ($rose(reset_n_in) |->
        cell_count_out == CELL_COUNT_MAX && !discharge_gate_drive_out
        && overvoltage_trip_mv_out == OV_TRIP_BASE_MV)
        else $error("reset values wrong");
    a_ov_drop: assert property (overvoltage_event_in[*4] |->
        !discharge_gate_drive_out) else $error("ov kept discharge on");
    a_uv_drop_both: assert property (undervoltage_event_in[*4] |->
        !discharge_gate_drive_out && !charge_gate_drive_out)
        else $error("uv kept a gate on");
    a_ts_pull_cause: assert property (thermistor_line_oe_out |->
        $past(overvoltage_event_in, 3)) else $error("ts pull without ov");
    a_delay_follows: assert property (
        $stable(zero_delay_test_input_in)[*4] |->
        delay_minimum_out == zero_delay_test_input_in)
        else $error("delay mode wrong");
    a_serial_off: assert property (
        (!zero_delay_test_input_in)[*5] |-> !serial_data_oe_out)
        else $error("serial active outside test mode");
    a_pulse_once: assert property (nv_write_pulse_out |=>
        !nv_write_pulse_out) else $error("commit pulse too long");
    a_pulse_test: assert property (nv_write_pulse_out |->
        delay_minimum_out) else $error("commit outside test mode");
    a_cur_latch: assert property (s_fault_seen ##1 s_load_stays |->
        !discharge_gate_drive_out) else $error("current fault not held");
    a_cell_range: assert property (
        cell_count_out >= CELL_COUNT_MIN && cell_count_out <= CELL_COUNT_MAX)
        else $error("cell count out of range");
    a_ov_grid: assert property (overvoltage_trip_mv_out <= 13'h1117 &&
        overvoltage_trip_mv_out >= OV_TRIP_BASE_MV && 13'h0 ==
        (overvoltage_trip_mv_out - OV_TRIP_BASE_MV) % OV_TRIP_STEP_MV)
        else $error("ov trip off grid");
endmodule // ppcb_bank_assertions
bind ppcb_bank ppcb_bank_assertions chk_u (.*);
`default_nettype wire

// >>> ppcb_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ppcb_bank_bench;
    import ppcb_pkg::*;
    typedef struct {string n; int lsb; int w; logic [12:0] v;} ppcb_exp_type;
    logic sys_clk_in = 1'h0, reset_n_in = 1'h0, serial_clock_in = 1'h1;
    logic sda_low = 1'h0, zero_delay_test_input_in = 1'h0, chg_on = 1'h0;
    logic nv_program_strobe_in = 1'h0, voltage_good_flag_in = 1'h1;
    logic overvoltage_event_in = 1'h0, undervoltage_event_in = 1'h0;
    logic overtemp_event_in = 1'h0, discharge_overcurrent_in = 1'h0;
    logic discharge_short_circuit_in = 1'h0;
    logic [15:0] load_mv = 16'h2EE0;
    logic [79:0] nv_image_in = 80'h0, nv_write_data_out;
    logic serial_data_in, serial_data_out, serial_data_oe_out;
    logic charger_status_input_in, load_return_below_2v_in, nv_write_pulse_out;
    logic discharge_gate_drive_out, charge_gate_drive_out, balance_enable_out;
    logic thermistor_line_oe_out, delay_minimum_out, thermal_sense_on_out;
    logic [3:0] cell_count_out;
    logic [12:0] overvoltage_trip_mv_out;
    logic [32:0] obs, seen;
    ppcb_exp_type q[$], e;
    int failures = 0, cmp_count = 0;
    ppcb_bank dut_u (.*);
    ppcb_equipment_model eq_u (.host_pull_low_in(sda_low),
        .dut_pull_low_in(serial_data_oe_out && !serial_data_out),
        .serial_data_out(serial_data_in), .charger_on_in(chg_on),
        .load_return_mv_in(load_mv), .charger_status_out(charger_status_input_in),
        .load_below_2v_out(load_return_below_2v_in));
    // Observed outputs packed by field position
    assign obs = {nv_write_data_out[7:0], nv_write_pulse_out, serial_data_oe_out,
        balance_enable_out, overvoltage_trip_mv_out, cell_count_out,
        thermal_sense_on_out, delay_minimum_out, thermistor_line_oe_out,
        charge_gate_drive_out, discharge_gate_drive_out};
    always #20 sys_clk_in = ~sys_clk_in;
    // All queued notes compared mid-cycle, once outputs have settled
    always @(negedge sys_clk_in) begin
        while (q.size() > 0) begin
            e = q.pop_front();
            seen = (obs >> e.lsb) & ((33'h1 << e.w) - 33'h1);
            cmp_count++;
            if (seen !== {20'h0, e.v}) begin
                failures++;
                $display("BAD %s expected %0h seen %0h", e.n, e.v, seen);
            end
        end
    end
    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic note(input string n, input int l, input int w,
                        input logic [12:0] v);
        q.push_back('{n, l, w, v});
    endtask
    task automatic gates(input logic d, input logic c);
        cyc(5);
        note("dsg", 0, 1, {12'h0, d});
        note("chg", 1, 1, {12'h0, c});
    endtask
    task automatic do_reset(input logic [79:0] img);
        nv_image_in = img;
        reset_n_in = 1'h0;
        cyc(5);
        reset_n_in = 1'h1;
        cyc(6);
    endtask
    // Data moves only mid-low so no false start or stop is seen
    task automatic sbit(input logic b);
        cyc(2);
        sda_low = !b;
        cyc(8);
        serial_clock_in = 1'h1;
        cyc(10);
        serial_clock_in = 1'h0;
    endtask
    task automatic sbyte(input logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) sbit(d[i]);
        sbit(1'h1);
        note("ack", 23, 1, {12'h0, ack});
    endtask
    task automatic swrite(input logic [7:0] ptr, input logic [7:0] d);
        cyc(10);
        sda_low = 1'h1;
        cyc(10);
        serial_clock_in = 1'h0;
        sbyte({SERIAL_DEVICE_ADDR, 1'h0}, zero_delay_test_input_in);
        if (zero_delay_test_input_in) sbyte(ptr, 1'h1);
        if (zero_delay_test_input_in) sbyte(d, 1'h1);
        cyc(2);
        sda_low = 1'h1;
        cyc(8);
        serial_clock_in = 1'h1;
        cyc(10);
        sda_low = 1'h0;
    endtask
    task automatic commit(input logic want, input logic [7:0] b0);
        int k;
        nv_program_strobe_in = 1'h1;
        for (k = 0; k < 20 && nv_write_pulse_out !== 1'h1; k++) cyc(1);
        note("pulse", 24, 1, {12'h0, want});
        if (want && k < 20) note("nv_byte0", 25, 8, {5'h0, b0});
        nv_program_strobe_in = 1'h0;
        cyc(4);
    endtask
    // Latch a current fault, then remove load, then attach charger
    task automatic cur_fault(input logic sc, input logic rec);
        discharge_overcurrent_in = !sc;
        discharge_short_circuit_in = sc;
        cyc(4);
        discharge_overcurrent_in = 1'h0;
        discharge_short_circuit_in = 1'h0;
        gates(1'h0, 1'h1);
        load_mv = 16'h0064;
        gates(rec, 1'h1);
        chg_on = 1'h1;
        gates(1'h1, 1'h1);
        load_mv = 16'h2EE0;
        chg_on = 1'h0;
    endtask
    initial begin
        logic [79:0] img;
        logic [5:0] ov;
        void'($urandom(17));
        img = 80'h0;
        // Cell codes, random trip codes, balance modes
        for (int i = 0; i < 4; i++) begin
            ov = 6'($urandom);
            img[15:0] = {2'h0, ov, 3'(i), 1'h0, 1'(i), 3'h0};
            img[79:72] = {2'(i), 6'h0};
            do_reset(img);
            note("cells", 5, 4, 13'(10 - i));
            note("ov_mv", 9, 13, 13'(2800 + 25 * int'(ov)));
            note("thermal", 4, 1, 13'(i % 2));
            note("balance", 22, 1, 13'(i % 2));
            note("delay", 3, 1, 13'h0);
        end
        do_reset({8'h80, 48'h0, 8'h80, 8'h00, 8'h08});
        overvoltage_event_in = 1'h1;
        gates(1'h0, 1'h1);
        note("ts_pull", 2, 1, 13'h1);
        overvoltage_event_in = 1'h0;
        undervoltage_event_in = 1'h1;
        gates(1'h0, 1'h0);
        undervoltage_event_in = 1'h0;
        chg_on = 1'h1;
        gates(1'h1, 1'h1);
        note("balance", 22, 1, 13'h1);
        chg_on = 1'h0;
        overtemp_event_in = 1'h1;
        gates(1'h0, 1'h0);
        overtemp_event_in = 1'h0;
        gates(1'h1, 1'h1);
        for (int s = 0; s < 2; s++) cur_fault(1'(s), 1'h1);
        do_reset({8'h80, 48'h0, 8'h80, 8'h00, 8'h1D});
        chg_on = 1'h1;
        overtemp_event_in = 1'h1;
        gates(1'h1, 1'h1);
        chg_on = 1'h0;
        gates(1'h0, 1'h0);
        overtemp_event_in = 1'h0;
        gates(1'h0, 1'h0);
        chg_on = 1'h1;
        gates(1'h1, 1'h1);
        chg_on = 1'h0;
        cur_fault(1'h1, 1'h0);
        swrite(8'h01, 8'h60);
        zero_delay_test_input_in = 1'h1;
        cyc(6);
        note("delay", 3, 1, 13'h1);
        swrite(8'h01, 8'h60);
        swrite(ADDR_PROGRAM_KEY, KEY_PRE_READ);
        commit(1'h0, 8'h00);
        swrite(8'h0C, 8'h55);
        swrite(ADDR_PROGRAM_KEY, KEY_UNLOCK_PROGRAM);
        commit(1'h1, 8'h1D);
        swrite(8'h01, 8'h60);
        swrite(ADDR_PROGRAM_KEY, KEY_UNLOCK_PROGRAM);
        commit(1'h1, 8'h60);
        note("cells", 5, 4, 13'h7);
        zero_delay_test_input_in = 1'h0;
        cyc(3);
        report_and_stop();
    end
endmodule // ppcb_bank_bench
`default_nettype wire
